// File: design/gpfs_defs.vh
// Register offsets, field positions, reset values and time-base counts for the pin format block
`ifndef GPFS_DEFS_VH
`define GPFS_DEFS_VH

`define GPFS_ADDR_W        8
`define GPFS_DATA_W        16
`define GPFS_NPINS         5

`define GPFS_OFS_CFG       8'h4D
`define GPFS_OFS_OUTDATA   8'h4E
`define GPFS_OFS_TIM_BASE  8'h4F
`define GPFS_OFS_TIM_LAST  8'h58
`define GPFS_OFS_LEVEL     8'h59

`define GPFS_CFG_RSVD_BIT  15
`define GPFS_CFG_FMT_LSB   10
`define GPFS_CFG_DIR_LSB   5
`define GPFS_CFG_SRC_LSB   0
`define GPFS_CFG_RSVD1_BIT 1
`define GPFS_CFG_RESET     16'h0000
`define GPFS_CFG_WMASK     16'h7FFD

`define GPFS_OUT_RESET     16'h0000
`define GPFS_TIM_RESET     16'h007F
`define GPFS_NTIM          10

`define GPFS_TB_MSB        15
`define GPFS_TB_LSB        14
`define GPFS_HC_MSB        13
`define GPFS_HC_LSB        7
`define GPFS_LC_MSB        6
`define GPFS_LC_LSB        0
`define GPFS_CNT_W         7
`define GPFS_CNT_MAX       7'h7F

`define GPFS_DIV_W         6
`define GPFS_DIV4_MASK     6'h03
`define GPFS_DIV16_MASK    6'h0F
`define GPFS_DIV64_MASK    6'h3F

`endif

// File: design/gpfs_pin_slice.v
// One pin: static or pulse-width drive, and static or pulse-width decode of the pin level
`timescale 1ns/1ps
`default_nettype none
`include "gpfs_defs.vh"

module gpfs_pin_slice (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // Time base enables: every cycle, /4, /16, /64
  input  wire [3:0]  tick_vec,
  // Configuration
  input  wire        fmt,
  input  wire        dir,
  input  wire        use_gpio,
  input  wire        out_value,
  input  wire        alt_value,
  input  wire [15:0] low_timing,
  input  wire [15:0] high_timing,
  // Pin
  input  wire        pin_in,
  output reg         pin_out_q,
  output reg         pin_oe_q,
  output reg         level_q
);

  wire                   tick;
  wire                   drive_val;
  wire [15:0]            shape;
  wire [`GPFS_CNT_W-1:0] target;
  reg  [`GPFS_CNT_W-1:0] gen_cnt_q;
  reg                    phase_q;
  reg                    prev_q;
  reg  [`GPFS_CNT_W-1:0] len_q;
  reg  [`GPFS_CNT_W-1:0] hi_len_q;

  ////////////////////////////////////////////////////////////////////////
  assign tick      = tick_vec[low_timing[`GPFS_TB_MSB:`GPFS_TB_LSB]];
  assign drive_val = use_gpio ? out_value : alt_value;
  // Low level uses the low timing word, high level the high one
  assign shape     = drive_val ? high_timing : low_timing;
  assign target    = phase_q ? shape[`GPFS_HC_MSB:`GPFS_HC_LSB] : shape[`GPFS_LC_MSB:`GPFS_LC_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Waveform generator, held idle in static format so timing words are ignored
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gen_cnt_q <= 7'h00;
      phase_q   <= 1'b1;
    end else if (!fmt || !dir) begin
      gen_cnt_q <= 7'h00;
      phase_q   <= 1'b1;
    end else if (tick) begin
      if (gen_cnt_q + 7'h01 >= target) begin
        gen_cnt_q <= 7'h00;
        phase_q   <= ~phase_q;
      end else begin
        gen_cnt_q <= gen_cnt_q + 7'h01;
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else begin
      pin_oe_q  <= dir;
      if (!dir) begin
        pin_out_q <= 1'b0;
      end else if (fmt) begin
        pin_out_q <= phase_q;
      end else begin
        pin_out_q <= drive_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoder: a period whose high part outlasts its low part reads as one.
  // Serves both inputs and readback of driven outputs, since it watches the pin.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q   <= 1'b0;
      len_q    <= 7'h00;
      hi_len_q <= 7'h00;
      level_q  <= 1'b0;
    end else begin
      prev_q <= pin_in;
      if (!fmt) begin
        len_q   <= 7'h00;
        level_q <= pin_in;
      end else if (prev_q && !pin_in) begin
        hi_len_q <= len_q;
        len_q    <= 7'h00;
      end else if (!prev_q && pin_in) begin
        level_q <= (hi_len_q > len_q);
        len_q   <= 7'h00;
      end else if (tick && len_q != `GPFS_CNT_MAX) begin
        // Saturates so a stuck pin does not wrap into a false reading
        len_q <= len_q + 7'h01;
      end
    end
  end

endmodule
`default_nettype wire

// File: design/gpfs_top.v
// Pin format select block: configuration registers, time base and five pin slices
//
// Behaviour
// - Config bit 15 is reserved and always reads zero.
// - Format bits: pin4 bit14, pin3 bit13, pin2 bit12, pin1 bit11, pin0 bit10.
// - Format zero on an input: logic value is the static pin level.
// - Format zero on an output: drive static level, ignore pulse timing words.
// - Format zero: readback of a driven output uses static level detection.
// - Format one on an input: decode the pulse-width waveform for the value.
// - Format one on an output: drive pulses shaped by low and high timing words.
// - Format one: readback decodes pulse width with the pin's time base.
// - Direction bit zero makes a digital input, one a digital output.
// - Output data bit drives the pin only for general digital output source.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gpfs_defs.vh"

module gpfs_top (
  // Clock and reset
  input  wire                    mclk,
  input  wire                    rst_n,
  // Register port
  input  wire [`GPFS_ADDR_W-1:0] reg_addr,
  input  wire [`GPFS_DATA_W-1:0] reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`GPFS_DATA_W-1:0] reg_rdata_q,
  // Alternate function data per pin
  input  wire [4:0]              alt_data,
  // Pins
  input  wire [4:0]              pin_in,
  output wire [4:0]              pin_out,
  output wire [4:0]              pin_oe
);

  reg  [`GPFS_DATA_W-1:0] cfg_q;
  reg  [`GPFS_DATA_W-1:0] out_q;
  reg  [`GPFS_DATA_W-1:0] tim_q [0:`GPFS_NTIM-1];
  reg  [`GPFS_DIV_W-1:0]  div_q;
  wire [3:0]              tick_vec;
  wire [4:0]              level;
  wire [4:0]              use_gpio;
  wire [`GPFS_ADDR_W-1:0] tim_idx;
  wire                    tim_hit;
  integer                 i;

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  assign tim_hit = (reg_addr >= `GPFS_OFS_TIM_BASE) && (reg_addr <= `GPFS_OFS_TIM_LAST);
  assign tim_idx = reg_addr - `GPFS_OFS_TIM_BASE;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `GPFS_CFG_RESET;
      out_q <= `GPFS_OUT_RESET;
      for (i = 0; i < `GPFS_NTIM; i = i + 1) begin
        tim_q[i] <= `GPFS_TIM_RESET;
      end
    end else if (reg_wr) begin
      if (reg_addr == `GPFS_OFS_CFG) begin
        // Reserved bits are never stored, so they cannot read back as one
        cfg_q <= reg_wdata & `GPFS_CFG_WMASK;
      end
      if (reg_addr == `GPFS_OFS_OUTDATA) begin
        out_q <= reg_wdata;
      end
      if (tim_hit) begin
        tim_q[tim_idx[3:0]] <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe; unmapped reads zero
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `GPFS_OFS_CFG) begin
        reg_rdata_q <= cfg_q & `GPFS_CFG_WMASK;
      end else if (reg_addr == `GPFS_OFS_OUTDATA) begin
        reg_rdata_q <= out_q;
      end else if (tim_hit) begin
        reg_rdata_q <= tim_q[tim_idx[3:0]];
      end else if (reg_addr == `GPFS_OFS_LEVEL) begin
        reg_rdata_q <= {11'h000, level};
      end else begin
        reg_rdata_q <= 16'h0000;
      end
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared time base; one counter feeds all pins so their periods stay aligned
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  assign tick_vec[0] = 1'b1;
  assign tick_vec[1] = ((div_q & `GPFS_DIV4_MASK) == `GPFS_DIV4_MASK);
  assign tick_vec[2] = ((div_q & `GPFS_DIV16_MASK) == `GPFS_DIV16_MASK);
  assign tick_vec[3] = ((div_q & `GPFS_DIV64_MASK) == `GPFS_DIV64_MASK);

  ////////////////////////////////////////////////////////////////////////
  // Pin 1 has no alternate function, so it always takes its data bit
  assign use_gpio = {cfg_q[`GPFS_CFG_SRC_LSB+4], cfg_q[`GPFS_CFG_SRC_LSB+3],
                     cfg_q[`GPFS_CFG_SRC_LSB+2], 1'b1, cfg_q[`GPFS_CFG_SRC_LSB]};

  genvar g;
  generate
    for (g = 0; g < `GPFS_NPINS; g = g + 1) begin : pin
      gpfs_pin_slice u_slice (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .tick_vec    (tick_vec),
        .fmt         (cfg_q[`GPFS_CFG_FMT_LSB+g]),
        .dir         (cfg_q[`GPFS_CFG_DIR_LSB+g]),
        .use_gpio    (use_gpio[g]),
        .out_value   (out_q[g]),
        .alt_value   (alt_data[g]),
        .low_timing  (tim_q[2*g]),
        .high_timing (tim_q[2*g+1]),
        .pin_in      (pin_in[g]),
        .pin_out_q   (pin_out[g]),
        .pin_oe_q    (pin_oe[g]),
        .level_q     (level[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// File: verif/gpfs_pin_far.sv
// Far-side logic that drives and receives the five pins
`timescale 1ns/1ps
`default_nettype none
module gpfs_pin_far (
  // Clock
  input  wire logic       mclk,
  // Block pins
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  // Bench control: static levels, pulse high and low lengths for pin 1
  input  wire logic [4:0] drv,
  input  wire logic [6:0] hi,
  input  wire logic [6:0] lo,
  output wire logic [4:0] pin_in
);
  logic [7:0] cnt_q = 8'h00;
  logic       pwm;
  always @(posedge mclk) begin
    cnt_q <= (cnt_q + 8'h01 >= {1'b0, hi} + {1'b0, lo}) ? 8'h00 : cnt_q + 8'h01;
  end
  assign pwm = (hi != 7'h00) && (cnt_q < {1'b0, hi});
  // Driven pins loop back, so readback sees the real wire
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {drv[4:2], drv[1] | pwm, drv[0]});
endmodule
`default_nettype wire

// File: verif/gpfs_top_assertions.sv
// Port checker for the pin format block
`timescale 1ns/1ps
`default_nettype none
module gpfs_top_chk (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_rdata_q,
  // Pins
  input  wire logic [4:0]  alt_data,
  input  wire logic [4:0]  pin_in,
  input  wire logic [4:0]  pin_out,
  input  wire logic [4:0]  pin_oe
);
  logic [15:0] cfg_q;
  logic [4:0]  dat_q;
  // Shadow copies; bits 15 and 1 are never stored
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 16'h0000;
      dat_q <= 5'h00;
    end else if (reg_wr && reg_addr == 8'h4D) begin
      cfg_q <= reg_wdata & 16'h7FFD;
    end else if (reg_wr && reg_addr == 8'h4E) begin
      dat_q <= reg_wdata[4:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rsvd; reg_rd && reg_addr == 8'h4D |=> !reg_rdata_q[15]; endproperty
  a_rsvd:
    assert property (p_rsvd) else $error("reserved config bit read as one");
  property p_cfg; reg_rd && reg_addr == 8'h4D |=> reg_rdata_q == cfg_q; endproperty
  a_cfg:
    assert property (p_cfg) else $error("config readback differs");
  property p_oe; pin_oe == $past(cfg_q[9:5]); endproperty
  a_oe:
    assert property (p_oe) else $error("enable not following direction");
  property p_gpio; $past(cfg_q[5] && cfg_q[0] && !cfg_q[10]) |-> pin_out[0] == $past(dat_q[0]); endproperty
  a_gpio:
    assert property (p_gpio) else $error("static output not the data bit");
  property p_alt; $past(cfg_q[7] && !cfg_q[2] && !cfg_q[12]) |-> pin_out[2] == $past(alt_data[2]); endproperty
  a_alt:
    assert property (p_alt) else $error("alternate output not followed");
  property p_in; $past(!cfg_q[6]) |-> !pin_out[1]; endproperty
  a_in:
    assert property (p_in) else $error("input pin driven high");
  property p_stat; (!cfg_q[11] && $stable(pin_in[1]))[*3] ##0 (reg_rd && reg_addr == 8'h59)
    |=> reg_rdata_q[1] == $past(pin_in[1]); endproperty
  a_stat:
    assert property (p_stat) else $error("static level misread");
  // Read data stands only in the cycle after the strobe
  property p_idle; !reg_rd |=> reg_rdata_q == 16'h0000; endproperty
  a_idle:
    assert property (p_idle) else $error("read data outside its cycle");
endmodule
bind gpfs_top gpfs_top_chk gpfs_top_chk_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .alt_data(alt_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// File: verif/gpfs_top_tb_top.sv
// Register-level testbench for the pin format block
`timescale 1ns/1ps
`default_nettype none
module gpfs_top_tb_top;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata_q;
  logic [15:0] rd_q;
  logic [4:0]  alt_data = 5'h00;
  logic [4:0]  drv = 5'h00;
  logic [4:0]  pin_in;
  logic [4:0]  pin_out;
  logic [4:0]  pin_oe;
  logic [6:0]  hi = 7'h00;
  logic [6:0]  lo = 7'h00;
  int          n_fail = 0;
  int          checked = 0;
  int          run;
  always #2 mclk = ~mclk;
  gpfs_top gpfs_top_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .alt_data(alt_data),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  gpfs_pin_far gpfs_pin_far_inst (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .drv(drv),
    .hi(hi), .lo(lo), .pin_in(pin_in));
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata_q;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Length of the next whole run at level lvl on pin 0; one shared bound so a stuck pin ends the run
  task automatic runlen(input logic lvl);
    int guard;
    guard = 0;
    run = 0;
    while (guard < 900 && pin_out[0] == lvl) begin
      guard++;
      @(negedge mclk);
    end
    while (guard < 900 && pin_out[0] != lvl) begin
      guard++;
      @(negedge mclk);
    end
    while (guard < 900 && pin_out[0] == lvl) begin
      guard++;
      run++;
      @(negedge mclk);
    end
    if (guard >= 900) begin
      n_fail++;
      $display("unexpected at %0t: pin 0 run did not end", $time);
      wrap_up();
    end
    @(posedge mclk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h4D);
    chk(rd_q, 16'h0000);
    wr(8'h4D, 16'hFFFF);
    rd(8'h4D);
    chk(rd_q, 16'h7FFD);
    rd(8'h80);
    chk(rd_q, 16'h0000);
    drv <= 5'h02;
    alt_data <= 5'h04;
    wr(8'h4D, 16'h00A1);
    wr(8'h4E, 16'h0001);
    // Driven level reaches the level register one cycle after the pin flop
    @(posedge mclk);
    rd(8'h59);
    chk(rd_q & 16'h0007, 16'h0007);
    drv <= 5'h00;
    hi <= 7'h06;
    lo <= 7'h02;
    wr(8'h4D, 16'h08A1);
    repeat (40) @(posedge mclk);
    rd(8'h59);
    chk(rd_q & 16'h0002, 16'h0002);
    hi <= 7'h02;
    lo <= 7'h06;
    repeat (40) @(posedge mclk);
    rd(8'h59);
    chk(rd_q & 16'h0002, 16'h0000);
    wr(8'h4F, 16'h0185);
    wr(8'h50, 16'h0302);
    wr(8'h4E, 16'h0000);
    wr(8'h4D, 16'h0CA1);
    runlen(1'b1);
    chk(run[15:0], 16'h0003);
    runlen(1'b0);
    chk(run[15:0], 16'h0005);
    rd(8'h59);
    chk(rd_q & 16'h0001, 16'h0000);
    wr(8'h4E, 16'h0001);
    runlen(1'b1);
    chk(run[15:0], 16'h0006);
    // Let a steady period pass so the decode is not from the shape change
    repeat (20) @(posedge mclk);
    rd(8'h59);
    chk(rd_q & 16'h0001, 16'h0001);
    wr(8'h4E, 16'h0000);
    wr(8'h4F, 16'h4185);
    runlen(1'b1);
    chk(run[15:0], 16'h000C);
    repeat (40) @(posedge mclk);
    rd(8'h59);
    chk(rd_q & 16'h0001, 16'h0000);
    wr(8'h4E, 16'h0001);
    wr(8'h4D, 16'h00A1);
    repeat (3) @(posedge mclk);
    chk({15'h0000, pin_out[0]}, 16'h0001);
    rd(8'h59);
    chk(rd_q & 16'h0001, 16'h0001);
    wrap_up();
  end
endmodule
`default_nettype wire
